// File: verilog/ccg_pkg.sv
// package: register map, field layout and constants of the clock generator control block
package ccg_pkg;
    // register indices as printed; byte address is four times the low IDX_W bits of the index
    localparam logic [31:0] IDX_PWR_SAVE = 32'hFFFFF070;
    localparam logic [31:0] IDX_SETTLE_SEL = 32'hFFFFF380;
    localparam logic [31:0] IDX_CLK_OUT = 32'hFFFFF38A;
    localparam logic [31:0] IDX_CPU_DIV = 32'hFFFFF071;
    localparam logic [31:0] IDX_UNLOCK = 32'hFFFFF0FC;
    localparam int IDX_W = 12;
    localparam int ADDR_W = 14;
    // reset values
    localparam logic [7:0] RST_PWR_SAVE = 8'h00;
    localparam logic [7:0] RST_SETTLE = 8'h04;
    localparam logic [7:0] RST_CLKOUT = 8'h00;
    localparam logic [7:0] RST_CPU_DIV = 8'h00;
    // field positions
    localparam int PWR_STOP_BIT = 1;
    localparam int PWR_WATCH_BIT = 2;
    localparam int CLK_OUT_EN_BIT = 4;
    localparam int FS_LSB = 0;
    localparam int CK_LSB = 0;
    localparam int SET_LSB = 0;
    localparam logic [2:0] SETTLE_MAX_CODE = 3'h4;
    // pll multiplies the oscillator by four
    localparam int PLL_MULT = 4;
    localparam int PRE_W = 4;
    localparam int SET_CNT_W = 16;
    // settle exponents for codes 0..4
    localparam logic [4:0] EXP_C0 = 5'hA;
    localparam logic [4:0] EXP_C1 = 5'hC;
    localparam logic [4:0] EXP_C2 = 5'hD;
    localparam logic [4:0] EXP_C3 = 5'hE;
    localparam logic [4:0] EXP_C4 = 5'hF;
    localparam logic [3:0] STRB_BYTE0 = 4'h1;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ccg_apb_req_s;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WATCH = 4'h2,
        ST_STOP = 4'h4,
        ST_SETTLE = 4'h8
    } ccg_mode_e;
endpackage

// File: verilog/ccg_ctrl.sv
// clock generator control: prescaler, power-save modes, protected writes, clock output pin
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ccg_ctrl
    import ccg_pkg::*;
#(
    parameter int SETTLE_SCALE_LOG2 = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire ccg_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_req,
    input wire logic instr_retire,
    input wire logic nonsample_instr,
    output logic irq_sample_block,
    output logic osc_ref_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic watch_clk_en,
    output logic cpu_hold,
    output logic clock_output_pin
);

    // true when the word index in the address matches a register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
        hit = (a[ADDR_W-1:2] == idx[IDX_W-1:0]);
    endfunction

    // divider tick: low code bits of the prescaler all ones
    function automatic logic div_tick(input logic [PRE_W-1:0] c, input logic [1:0] code);
        logic [PRE_W-1:0] m;
        m = PRE_W'((1 << code) - 1);
        div_tick = ((c & m) == m);
    endfunction

    // settle length for a code; scaled down only for short simulations
    function automatic logic [SET_CNT_W-1:0] settle_len(input logic [2:0] code);
        logic [4:0] e;
        case (code)
            3'h0: e = EXP_C0;
            3'h1: e = EXP_C1;
            3'h2: e = EXP_C2;
            3'h3: e = EXP_C3;
            default: e = EXP_C4;
        endcase
        settle_len = SET_CNT_W'(1 << (e - 5'(SETTLE_SCALE_LOG2)));
    endfunction

    logic wr;
    logic rd_ok;
    logic acc;
    logic mapped;
    logic byte0;
    logic unlock_armed;
    logic prot_ok;
    logic [1:0] cpu_div;
    logic stop_req;
    logic watch_req;
    logic [2:0] settle_code;
    logic clk_out_en;
    logic [1:0] pin_freq;
    logic [PRE_W-1:0] prescale;
    logic [SET_CNT_W-1:0] settle_cnt;
    logic wake_meta;
    logic wake_sync;
    logic pin_q;
    ccg_mode_e mode;
    ccg_mode_e next_mode;

    // apb decode; zero wait states keep every access one access cycle long
    assign acc = apb_req.psel & apb_req.penable;
    assign wr = acc & apb_req.pwrite;
    assign byte0 = apb_req.pstrb[0];
    assign mapped = hit(apb_req.paddr, IDX_PWR_SAVE) | hit(apb_req.paddr, IDX_SETTLE_SEL)
        | hit(apb_req.paddr, IDX_CLK_OUT) | hit(apb_req.paddr, IDX_CPU_DIV)
        | hit(apb_req.paddr, IDX_UNLOCK);
    assign rd_ok = acc & ~apb_req.pwrite & mapped;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prot_ok = wr & byte0 & unlock_armed;

    // unlock is good for exactly the next transfer, whatever it is
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_armed <= 1'b0;
        end else if (acc) begin
            unlock_armed <= wr & hit(apb_req.paddr, IDX_UNLOCK);
        end
    end

    // interrupt sampling is blocked from a non-sampling instruction to the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sample_block <= 1'b0;
        end else if (nonsample_instr | (wr & hit(apb_req.paddr, IDX_UNLOCK))) begin
            irq_sample_block <= 1'b1;
        end else if (instr_retire) begin
            irq_sample_block <= 1'b0;
        end
    end

    // protected divider register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_div <= RST_CPU_DIV[CK_LSB +: 2];
        end else if (prot_ok && hit(apb_req.paddr, IDX_CPU_DIV)) begin
            cpu_div <= apb_req.pwdata[CK_LSB +: 2];
        end
    end

    // protected power-save bits; hardware clears the bit of the mode it leaves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_req <= RST_PWR_SAVE[PWR_STOP_BIT];
            watch_req <= RST_PWR_SAVE[PWR_WATCH_BIT];
        end else if (mode == ST_STOP && wake_sync) begin
            stop_req <= 1'b0;
        end else if (mode == ST_WATCH && wake_sync) begin
            watch_req <= 1'b0;
        end else if (prot_ok && hit(apb_req.paddr, IDX_PWR_SAVE)) begin
            stop_req <= apb_req.pwdata[PWR_STOP_BIT];
            watch_req <= apb_req.pwdata[PWR_WATCH_BIT];
        end
    end

    // settle select: whole byte writes only, prohibited codes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_code <= RST_SETTLE[SET_LSB +: 3];
        end else if (wr && hit(apb_req.paddr, IDX_SETTLE_SEL) && apb_req.pstrb == STRB_BYTE0
                && apb_req.pwdata[SET_LSB +: 3] <= SETTLE_MAX_CODE) begin
            settle_code <= apb_req.pwdata[SET_LSB +: 3];
        end
    end

    // clock output mode register, not protected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_en <= RST_CLKOUT[CLK_OUT_EN_BIT];
            pin_freq <= RST_CLKOUT[FS_LSB +: 2];
        end else if (wr && byte0 && hit(apb_req.paddr, IDX_CLK_OUT)) begin
            clk_out_en <= apb_req.pwdata[CLK_OUT_EN_BIT];
            pin_freq <= apb_req.pwdata[FS_LSB +: 2];
        end
    end

    // read mux; protected registers need no unlock to read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(apb_req.paddr, IDX_PWR_SAVE)) begin
                prdata[PWR_STOP_BIT] <= stop_req;
                prdata[PWR_WATCH_BIT] <= watch_req;
            end else if (hit(apb_req.paddr, IDX_CPU_DIV)) begin
                prdata[CK_LSB +: 2] <= cpu_div;
            end else if (hit(apb_req.paddr, IDX_SETTLE_SEL)) begin
                prdata[SET_LSB +: 3] <= settle_code;
            end else if (hit(apb_req.paddr, IDX_CLK_OUT)) begin
                prdata[CLK_OUT_EN_BIT] <= clk_out_en;
                prdata[FS_LSB +: 2] <= pin_freq;
            end
        end
    end

    // wake pin is asynchronous: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_req;
            wake_sync <= wake_meta;
        end
    end

    // mode sequencer; stop wins if software sets both bits
    always_comb begin
        next_mode = mode;
        case (mode)
            ST_RUN: begin
                if (stop_req) begin
                    next_mode = ST_STOP;
                end else if (watch_req) begin
                    next_mode = ST_WATCH;
                end
            end
            ST_WATCH, ST_STOP: begin
                if (wake_sync) begin
                    next_mode = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_cnt == settle_len(settle_code) - SET_CNT_W'(1)) begin
                    next_mode = ST_RUN;
                end
            end
            default: next_mode = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ST_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // settle counter counts main cycles only; oscillator start-up is not in it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= '0;
        end else if (mode == ST_SETTLE) begin
            settle_cnt <= settle_cnt + SET_CNT_W'(1);
        end else begin
            settle_cnt <= '0;
        end
    end

    // free-running prescaler, parked in stop so nothing ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (mode != ST_STOP) begin
            prescale <= prescale + PRE_W'(1);
        end
    end

    // clock enables per domain; watch logic survives watch mode only
    assign osc_ref_en = (mode != ST_STOP)
        && (prescale[1:0] == 2'(PLL_MULT - 1));
    assign cpu_hold = (mode != ST_RUN);
    assign cpu_clk_en = (mode == ST_RUN) && div_tick(prescale, cpu_div);
    assign periph_clk_en = (mode == ST_RUN) || (mode == ST_SETTLE);
    assign watch_clk_en = (mode != ST_STOP);

    // pin toggles every 2^fs main cycles, giving main/2 up to main/16
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else if (!clk_out_en || mode == ST_STOP || mode == ST_WATCH) begin
            pin_q <= 1'b0;
        end else if (div_tick(prescale, pin_freq)) begin
            pin_q <= ~pin_q;
        end
    end
    assign clock_output_pin = pin_q;

    // assertions
    sequence s_unlock;
        wr && hit(apb_req.paddr, IDX_UNLOCK);
    endsequence
    sequence s_wake_settle;
        mode == ST_SETTLE && settle_cnt == '0;
    endsequence

    a_unprotected_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && hit(apb_req.paddr, IDX_CPU_DIV) && !unlock_armed)
        |=> $stable(cpu_div))
        else $error("divider changed without unlock");
    a_unlocked_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_unlock ##1 (apb_req.psel && !apb_req.penable) [*1] ##1
        (wr && byte0 && hit(apb_req.paddr, IDX_CPU_DIV))
        |=> cpu_div == $past(apb_req.pwdata[CK_LSB +: 2]))
        else $error("unlocked divider write lost");
    a_unlock_blocks_irq: assert property (@(posedge pclk) disable iff (!presetn)
        s_unlock |=> irq_sample_block)
        else $error("interrupts not blocked after unlock store");
    a_nonsample_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (nonsample_instr && !instr_retire) ##1 !instr_retire |-> irq_sample_block)
        else $error("interrupt window opened too early");
    a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        mode == ST_STOP |-> !cpu_clk_en && !periph_clk_en && !watch_clk_en && !osc_ref_en)
        else $error("clock running in stop");
    a_watch_clocks: assert property (@(posedge pclk) disable iff (!presetn)
        mode == ST_WATCH |-> !cpu_clk_en && !periph_clk_en && watch_clk_en)
        else $error("wrong clocks in watch");
    a_pin_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_out_en ##1 !clk_out_en |-> !clock_output_pin)
        else $error("clock pin not low while disabled");
    a_pin_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_out_en && pin_freq == 2'h0 && mode == ST_RUN) [*3]
        |-> clock_output_pin != $past(clock_output_pin))
        else $error("clock pin not at main/2");
    a_cpu_div_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (cpu_clk_en && cpu_div == 2'h1) ##1 (cpu_div == 2'h1) |-> !cpu_clk_en)
        else $error("cpu divider rate wrong");
    a_settle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s_wake_settle |-> cpu_hold [*8])
        else $error("cpu released before settle");
    a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == ST_STOP && wake_sync) |=> !stop_req && mode == ST_SETTLE)
        else $error("stop bit not cleared on release");
    a_watch_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == ST_WATCH && wake_sync) |=> !watch_req && mode == ST_SETTLE)
        else $error("watch bit not cleared on release");
    a_osc_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        (osc_ref_en && mode == ST_RUN) |=> !osc_ref_en ##1 !osc_ref_en ##1 !osc_ref_en)
        else $error("oscillator reference not main/4");

endmodule // ccg_ctrl

// File: verif/clock_generator_control_test.sv
// self-checking bench for the clock generator control block
`timescale 1ns/1ps
module clock_generator_control_test
    import ccg_pkg::*;
;
    localparam int SCALE = 6;
    localparam logic [13:0] A_PWR = {IDX_PWR_SAVE[11:0], 2'b00};
    localparam logic [13:0] A_DIV = {IDX_CPU_DIV[11:0], 2'b00};
    localparam logic [13:0] A_UNL = {IDX_UNLOCK[11:0], 2'b00};
    localparam logic [13:0] A_SET = {IDX_SETTLE_SEL[11:0], 2'b00};
    localparam logic [13:0] A_CLO = {IDX_CLK_OUT[11:0], 2'b00};
    localparam int EXPS [5] = '{10, 12, 13, 14, 15};
    logic pclk, presetn, wake_req, instr_retire, nonsample_instr;
    ccg_apb_req_s req;
    logic [31:0] prdata;
    logic pready, pslverr, irq_sample_block, osc_ref_en, cpu_clk_en, periph_clk_en;
    logic watch_clk_en, cpu_hold, clock_output_pin;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    // model of the register contents, brought up to date before each read that checks it
    int m_pwr = 0, m_set = 4, m_clo = 0, m_div = 0;

    ccg_ctrl #(.SETTLE_SCALE_LOG2(SCALE)) i_ccg_ctrl (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_req(wake_req), .instr_retire(instr_retire), .nonsample_instr(nonsample_instr),
        .irq_sample_block(irq_sample_block), .osc_ref_en(osc_ref_en),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .watch_clk_en(watch_clk_en), .cpu_hold(cpu_hold),
        .clock_output_pin(clock_output_pin));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // hang guard: the whole run needs under two thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one apb transfer; called just after a rising edge, release only when last is set
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic last);
        req <= '{1'b1, 1'b0, wr, a, d, s};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // an idle edge after a release keeps req to one assignment per time step
        if (last) begin
            req <= '0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, STRB_BYTE0, 1'b1);
    endtask

    // unlock store with arbitrary data, then the protected store at once
    task automatic pwr(input logic [13:0] a, input logic [7:0] d);
        apb(1'b1, A_UNL, {24'h0, d}, STRB_BYTE0, 1'b0);
        apb(1'b1, a, {24'h0, d}, STRB_BYTE0, 1'b1);
    endtask

    task automatic rchk(input string what, input logic [13:0] a, input int exp);
        apb(1'b0, a, 32'h0, 4'h0, 1'b1);
        chk(what, 32'(exp), rd);
        chk1("read error flag", 1'b0, err);
    endtask

    task automatic irq_step(input logic ns, input logic ret, input logic exp);
        @(posedge pclk);
        nonsample_instr <= ns;
        instr_retire <= ret;
        @(posedge pclk);
        nonsample_instr <= 1'b0;
        instr_retire <= 1'b0;
        @(negedge pclk);
        chk1("irq_sample_block", exp, irq_sample_block);
        @(posedge pclk);
    endtask

    // counts cpu enables, oscillator ticks and pin changes over 64 main cycles
    task automatic count_pulses(output int n_cpu, output int n_osc, output int n_pin);
        logic prev;
        n_cpu = 0;
        n_osc = 0;
        n_pin = 0;
        @(negedge pclk);
        prev = clock_output_pin;
        repeat (64) begin
            @(negedge pclk);
            n_cpu += int'(cpu_clk_en === 1'b1);
            n_osc += int'(osc_ref_en === 1'b1);
            n_pin += int'(clock_output_pin !== prev);
            prev = clock_output_pin;
        end
        @(posedge pclk);
    endtask

    // enter a low-power mode, wake it and time the settle hold
    task automatic power_cycle(input logic [7:0] pwr_bits, input int code);
        int n;
        wr(A_SET, code[7:0]);
        m_set = code;
        pwr(A_PWR, pwr_bits);
        m_pwr = pwr_bits;
        // five idle instruction slots before anything else touches the block
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        chk1("cpu_hold in mode", 1'b1, cpu_hold);
        chk1("cpu_clk_en in mode", 1'b0, cpu_clk_en);
        chk1("periph_clk_en in mode", 1'b0, periph_clk_en);
        chk1("watch_clk_en in mode", pwr_bits == 8'h04, watch_clk_en);
        chk1("pin in mode", 1'b0, clock_output_pin);
        @(posedge pclk);
        rchk("power save in mode", A_PWR, m_pwr);
        wake_req <= 1'b1;
        n = 0;
        // settle cycles are those with the cpu held but peripherals clocked
        do begin
            @(negedge pclk);
            n += int'(cpu_hold === 1'b1 && periph_clk_en === 1'b1);
        end while (cpu_hold !== 1'b0);
        @(posedge pclk);
        wake_req <= 1'b0;
        chk("settle cycles", 32'((1 << EXPS[code]) >> SCALE), 32'(n));
        m_pwr = 0;
        rchk("power save after wake", A_PWR, m_pwr);
    endtask

    initial begin
        int rot, fs, n_cpu, n_osc, n_pin;
        req = '0;
        wake_req = 1'b0;
        instr_retire = 1'b0;
        nonsample_instr = 1'b0;
        presetn = 1'b0;
        void'($urandom(32'h4bc5));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("power save reset", A_PWR, m_pwr);
        rchk("settle reset", A_SET, m_set);
        rchk("clkout reset", A_CLO, m_clo);
        rchk("divider reset", A_DIV, m_div);
        // unmapped place answers with an error and zero data
        apb(1'b0, 14'h004, 32'h0, 4'h0, 1'b1);
        chk("unmapped data", 32'h0, rd);
        chk1("unmapped error", 1'b1, err);
        // protected stores without a proper unlock or a byte 0 strobe are dropped, as are bad settle selects
        wr(A_DIV, 8'h03);
        rchk("divider no unlock", A_DIV, m_div);
        apb(1'b1, A_UNL, $urandom, STRB_BYTE0, 1'b1);
        irq_step(1'b0, 1'b0, 1'b1);
        rchk("power save between", A_PWR, m_pwr);
        wr(A_DIV, 8'h03);
        rchk("divider disarmed", A_DIV, m_div);
        irq_step(1'b0, 1'b1, 1'b0);
        irq_step(1'b1, 1'b0, 1'b1);
        irq_step(1'b0, 1'b1, 1'b0);
        apb(1'b1, A_UNL, 32'h0, STRB_BYTE0, 1'b0);
        apb(1'b1, A_DIV, 32'h3, 4'h2, 1'b1);
        rchk("divider strobe", A_DIV, m_div);
        apb(1'b1, A_SET, 32'h0, 4'hF, 1'b1);
        rchk("settle word strobe", A_SET, m_set);
        wr(A_SET, 8'h05);
        rchk("settle prohibited", A_SET, m_set);
        wr(A_PWR, 8'h02);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk1("hold after bare store", 1'b0, cpu_hold);
        @(posedge pclk);
        // every divider and pin code, pin codes in a random rotation
        rot = $urandom_range(3, 0);
        for (int k = 0; k < 4; k++) begin
            fs = (k + rot) % 4;
            pwr(A_DIV, 8'(k));
            m_div = k;
            wr(A_CLO, 8'h00);
            m_clo = 8'h10 | fs;
            wr(A_CLO, 8'(m_clo));
            rchk("divider", A_DIV, m_div);
            rchk("clkout", A_CLO, m_clo);
            count_pulses(n_cpu, n_osc, n_pin);
            chk("cpu enables", 32'(64 >> k), 32'(n_cpu));
            chk("osc ticks", 32'(64 / 4), 32'(n_osc));
            chk("pin changes", 32'(64 >> fs), 32'(n_pin));
        end
        wr(A_CLO, 8'h00);
        count_pulses(n_cpu, n_osc, n_pin);
        chk("pin changes off", 32'h0, 32'(n_pin));
        chk1("pin off", 1'b0, clock_output_pin);
        wr(A_CLO, 8'h10);
        power_cycle(8'h02, 4);
        power_cycle(8'h04, $urandom_range(4, 1));
        wrap_up();
    end
endmodule // clock_generator_control_test
